// ### dv/sample_fifo_irq_control_test.sv
`timescale 1ns/1ps
module sample_fifo_irq_control_test;
  import sfq_pkg::*;
  logic clock, rstn, go, wr, done, err, sv, ad, ao, ln, tr, pv, roll;
  logic psel, penable, pwrite, pready, pslverr, irq, pm, st;
  logic [5:0] idx;
  logic [7:0] wdat, rdat, sd, rd, paddr, pc, rs, d, f, th;
  logic [6:0] wp, rp, rp0, lost;
  logic [18:0] pr;
  logic [31:0] pwdata, prdata;
  logic [7:0] q[$];
  int failures, num_checks, cyc, n;

  sfq_top #(.PROX_TICK_DIV(8)) dut_u (.clock(clock), .rstn(rstn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_valid(sv), .sample_data(sd), .auth_done(ad),
    .ambient_overflow(ao), .led_noncompliant(ln), .temp_ready(tr),
    .prox_result_valid(pv), .prox_result(pr), .irq(irq),
    .proximity_mode(pm), .slow_tick(st), .pilot_current(pc),
    .rate_select(rs));
  sfq_host_model host_u (.clock(clock), .rstn(rstn), .go(go), .wr(wr),
    .idx(idx), .wdat(wdat), .done(done), .rdat(rdat), .err(err),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  // Free-running clock at 10 MHz.
  initial begin
    clock = 1'b0;
    forever #50 clock = ~clock;
  end

  // A hang counts as a mismatch and ends the run.
  always @(posedge clock) begin
    cyc++;
    if (cyc == 40000) begin
      failures++;
      conclude();
    end
  end

  task automatic conclude();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task automatic chk(string what, logic [7:0] seen, logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One register access through the host model; read data lands in rd.
  task automatic bus(logic w, logic [5:0] i, logic [7:0] dv);
    int k;
    k = 0;
    @(posedge clock);
    go <= 1'b1;
    wr <= w;
    idx <= i;
    wdat <= dv;
    do begin
      @(posedge clock);
      k++;
    end while (done !== 1'b1 && k < 50);
    go <= 1'b0;
    rd = rdat;
    if (k >= 50) failures++;
  endtask

  task automatic rdchk(string what, logic [5:0] i, logic [7:0] exp);
    bus(1'b0, i, 8'h00);
    chk(what, rd, exp);
  endtask

  // Back-to-back samples; the queue mirrors what the host should read.
  task automatic push(int cnt);
    logic [7:0] v;
    for (int k = 0; k < cnt; k++) begin
      @(posedge clock);
      v = 8'($urandom);
      sv <= 1'b1;
      sd <= v;
      if (q.size() == SFQ_DEPTH) begin
        if (lost != SFQ_LOST_MAX) lost++;
        if (roll) begin
          void'(q.pop_front());
          rp++;
        end
      end
      if (q.size() < SFQ_DEPTH) begin
        q.push_back(v);
        wp++;
      end
    end
    @(posedge clock);
    sv <= 1'b0;
  endtask

  // Proximity holds while the result is below 2048 times the threshold.
  function automatic logic exp_near(logic [18:0] r, logic [7:0] k);
    return 32'(r) < 2048 * 32'(k);
  endfunction

  // One proximity result; ticks are counted over two pacing periods.
  task automatic prox(logic [18:0] r);
    logic m;
    int t;
    m = exp_near(r, th);
    t = 0;
    @(posedge clock);
    pv <= 1'b1;
    pr <= r;
    @(posedge clock);
    pv <= 1'b0;
    repeat (3) @(posedge clock);
    chk("mode", {7'h00, pm}, {7'h00, m});
    chk("pilot", pc, m ? d : 8'h00);
    chk("irq prox", {7'h00, irq}, 8'h01);
    repeat (16) begin
      @(posedge clock);
      if (st === 1'b1) t++;
    end
    chk("tick", 8'(t), m ? 8'h02 : 8'h00);
    bus(1'b0, SFQ_IDX_STATUS_MAIN, 8'h00);
    chk("prox flag", rd & 8'h10, 8'h10);
  endtask

  initial begin
    {rstn, go, wr, sv, ad, ao, ln, tr, pv, roll} = 10'h000;
    {idx, wdat, sd, pr, wp, rp, lost} = '0;
    void'($urandom(32'h42b44ec5));
    repeat (4) @(posedge clock);
    rstn <= 1'b1;
    // Reset values; the data port is skipped since storage is not reset.
    for (int i = 1; i <= 9; i++) begin
      if (i != 8) rdchk("reset", 6'(i), i == 9 ? 8'h3F : 8'h00);
    end
    bus(1'b0, 6'h3F, 8'h00);
    chk("slverr", {7'h00, err}, 8'h01);
    d = 8'($urandom);
    bus(1'b1, SFQ_IDX_IRQ_EN_MAIN, d);
    rdchk("en main", SFQ_IDX_IRQ_EN_MAIN, d & 8'hFC);
    bus(1'b1, SFQ_IDX_IRQ_EN_MAIN, 8'h00);
    bus(1'b1, SFQ_IDX_IRQ_EN_AUTH, 8'h01);
    // Authentication flag raises the interrupt and clears on read.
    @(posedge clock) ad <= 1'b1;
    @(posedge clock) ad <= 1'b0;
    repeat (2) @(posedge clock);
    chk("irq auth", {7'h00, irq}, 8'h01);
    rdchk("auth", SFQ_IDX_AUTH_STATUS, 8'h01);
    rdchk("auth", SFQ_IDX_AUTH_STATUS, 8'h00);
    chk("irq off", {7'h00, irq}, 8'h00);
    @(posedge clock) {ao, ln, tr} <= 3'h7;
    @(posedge clock) {ao, ln, tr} <= 3'h0;
    rdchk("events", SFQ_IDX_STATUS_MAIN, 8'h2C);
    // Random burst, drained through the data port, then reread.
    n = 1 + ($urandom % 20);
    rp0 = rp;
    push(n);
    f = q[0];
    rdchk("wr index", SFQ_IDX_WRITE_INDEX, {1'b0, wp});
    rdchk("occupancy", SFQ_IDX_OCCUPANCY, 8'(q.size()));
    while (q.size() > 0) begin
      rdchk("data", SFQ_IDX_READ_PORT, q.pop_front());
      rp++;
    end
    rdchk("rd index", SFQ_IDX_READ_INDEX, {1'b0, rp});
    bus(1'b1, SFQ_IDX_READ_INDEX, {1'b0, rp0});
    rdchk("reread count", SFQ_IDX_OCCUPANCY, 8'(n));
    rdchk("reread", SFQ_IDX_READ_PORT, f);
    bus(1'b1, SFQ_IDX_QUEUE_CFG, 8'h10);
    {wp, rp} = 14'h0000;
    rdchk("flush", SFQ_IDX_WRITE_INDEX, 8'h00);
    rdchk("flush", SFQ_IDX_OCCUPANCY, 8'h00);
    rdchk("self clear", SFQ_IDX_QUEUE_CFG, 8'h00);
    // Almost-full boundary at two entries, then fill past full.
    bus(1'b1, SFQ_IDX_THRESH_CFG, 8'h7E);
    bus(1'b0, SFQ_IDX_STATUS_MAIN, 8'h00);
    push(1);
    bus(1'b0, SFQ_IDX_STATUS_MAIN, 8'h00);
    chk("afull early", rd & 8'h80, 8'h00);
    push(1);
    bus(1'b0, SFQ_IDX_STATUS_MAIN, 8'h00);
    chk("afull", rd & 8'h80, 8'h80);
    push(1);
    bus(1'b0, SFQ_IDX_STATUS_MAIN, 8'h00);
    chk("afull repeat", rd & 8'h80, 8'h80);
    bus(1'b1, SFQ_IDX_QUEUE_CFG, 8'h04);
    push(1);
    bus(1'b0, SFQ_IDX_STATUS_MAIN, 8'h00);
    chk("afull once", rd & 8'h80, 8'h00);
    push(128);
    rdchk("full", SFQ_IDX_OCCUPANCY, SFQ_DEPTH_COUNT);
    rdchk("lost", SFQ_IDX_LOST_COUNT, {1'b0, lost});
    rdchk("hold", SFQ_IDX_WRITE_INDEX, {1'b0, wp});
    roll = 1'b1;
    bus(1'b1, SFQ_IDX_QUEUE_CFG, 8'h0A);
    push(3);
    rdchk("roll wr", SFQ_IDX_WRITE_INDEX, {1'b0, wp});
    rdchk("roll rd", SFQ_IDX_READ_INDEX, {1'b0, rp});
    rdchk("oldest", SFQ_IDX_READ_PORT, q.pop_front());
    rp++;
    bus(1'b0, SFQ_IDX_STATUS_MAIN, 8'h00);
    chk("stat clr", rd & 8'h40, 8'h00);
    push(130);
    rdchk("saturate", SFQ_IDX_LOST_COUNT, SFQ_LOST_MAX);
    // Proximity entry, exit and disable.
    d = 8'($urandom);
    bus(1'b1, SFQ_IDX_PILOT_CUR, d);
    bus(1'b1, SFQ_IDX_RATE_SEL, 8'h5A);
    @(posedge clock);
    chk("rate", rs, 8'h5A);
    th = 8'(1 + ($urandom % 255));
    bus(1'b1, SFQ_IDX_PROX_THRESH, th);
    bus(1'b1, SFQ_IDX_IRQ_EN_MAIN, 8'h10);
    prox(19'(2048 * th - 1));
    prox(19'(2048 * th));
    prox(19'($urandom % (2048 * th)));
    bus(1'b1, SFQ_IDX_IRQ_EN_MAIN, 8'h00);
    repeat (2) @(posedge clock);
    chk("disable", {7'h00, pm}, 8'h00);
    bus(1'b0, SFQ_IDX_STATUS_MAIN, 8'h00);
    chk("no flag", rd & 8'h10, 8'h00);
    conclude();
  end
endmodule // sample_fifo_irq_control_test

// ### dv/sfq_host_model.sv
`timescale 1ns/1ps
// Host processor model: turns one bench request into one APB transfer.
module sfq_host_model (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // Request from the bench.
  input wire logic go,
  input wire logic wr,
  input wire logic [5:0] idx,
  input wire logic [7:0] wdat,
  output logic done,
  output logic [7:0] rdat,
  output logic err,
  // APB master side.
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [7:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Request is held until pready is seen; paddr and pwdata are then inverted so
  // a slave that samples them late sees garbage rather than stale values.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      {psel, penable, pwrite, done, err} <= 5'h00;
      paddr <= 8'h00;
      pwdata <= 32'h0000_0000;
      rdat <= 8'h00;
    end else begin
      done <= 1'b0;
      if (psel && penable && pready) begin
        psel <= 1'b0;
        penable <= 1'b0;
        done <= 1'b1;
        rdat <= prdata[7:0];
        err <= pslverr;
        paddr <= ~paddr;
        pwdata <= ~pwdata;
      end else if (psel) begin
        penable <= 1'b1;
      end else if (go && !done) begin
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wdat};
      end
    end
  end
endmodule // sfq_host_model

// ### rtl/sfq_pkg.sv
package sfq_pkg;

  // Clock and proximity sampling rate.
  localparam int SFQ_CLK_HZ = 10_000_000;
  localparam int SFQ_PROX_RATE_HZ = 8;
  localparam int SFQ_PROX_TICK_CYCLES = SFQ_CLK_HZ / SFQ_PROX_RATE_HZ;

  // Register indices; the byte address is four times the index.
  localparam logic [5:0] SFQ_IDX_STATUS_MAIN = 6'h00;
  localparam logic [5:0] SFQ_IDX_AUTH_STATUS = 6'h01;
  localparam logic [5:0] SFQ_IDX_IRQ_EN_MAIN = 6'h02;
  localparam logic [5:0] SFQ_IDX_IRQ_EN_AUTH = 6'h03;
  localparam logic [5:0] SFQ_IDX_WRITE_INDEX = 6'h04;
  localparam logic [5:0] SFQ_IDX_READ_INDEX = 6'h05;
  localparam logic [5:0] SFQ_IDX_LOST_COUNT = 6'h06;
  localparam logic [5:0] SFQ_IDX_OCCUPANCY = 6'h07;
  localparam logic [5:0] SFQ_IDX_READ_PORT = 6'h08;
  localparam logic [5:0] SFQ_IDX_THRESH_CFG = 6'h09;
  localparam logic [5:0] SFQ_IDX_QUEUE_CFG = 6'h0A;
  localparam logic [5:0] SFQ_IDX_PROX_THRESH = 6'h10;
  localparam logic [5:0] SFQ_IDX_PILOT_CUR = 6'h11;
  localparam logic [5:0] SFQ_IDX_RATE_SEL = 6'h12;

  // Status and enable bit positions (shared layout).
  localparam int SFQ_BIT_AFULL = 7;
  localparam int SFQ_BIT_DRDY = 6;
  localparam int SFQ_BIT_AMB = 5;
  localparam int SFQ_BIT_PROX = 4;
  localparam int SFQ_BIT_LEDC = 3;
  localparam int SFQ_BIT_TEMP = 2;
  localparam int SFQ_BIT_AUTH = 0;

  // Queue configuration bit positions.
  localparam int SFQ_BIT_FLUSH = 4;
  localparam int SFQ_BIT_STATCLR = 3;
  localparam int SFQ_BIT_AFTYPE = 2;
  localparam int SFQ_BIT_ROLL = 1;

  // Sizes and reset values.
  localparam int SFQ_DEPTH = 128;
  localparam logic [7:0] SFQ_DEPTH_COUNT = 8'h80;
  localparam logic [6:0] SFQ_AFULL_RST = 7'h3F;
  localparam logic [6:0] SFQ_LOST_MAX = 7'h7F;
  localparam logic [7:0] SFQ_BYTE_RST = 8'h00;
  localparam logic [10:0] SFQ_PROX_SCALE_ZEROS = 11'h000;

  // Acquisition mode.
  typedef enum logic {SFQ_MODE_NORMAL, SFQ_MODE_PROX} sfq_mode_t;

endpackage

// ### rtl/sfq_ram.sv
`timescale 1ns/1ps
// Sample storage with one write port and an asynchronous read port.
module sfq_ram #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 128,
  parameter int AW = 7
) (
  // Clock.
  input wire logic clock,
  // Write side.
  input wire logic wr_en,
  input wire logic [AW-1:0] wr_addr,
  input wire logic [WIDTH-1:0] wr_data,
  // Read side.
  input wire logic [AW-1:0] rd_addr,
  output logic [WIDTH-1:0] rd_data
);

  logic [WIDTH-1:0] mem [DEPTH];

  // Contents are not reset; a flush only moves the pointers.
  always_ff @(posedge clock) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
  end

  assign rd_data = mem[rd_addr];

endmodule // sfq_ram

// ### rtl/sfq_top.sv
// Register access over APB was decided locally.
`timescale 1ns/1ps
module sfq_top
  import sfq_pkg::*;
#(
  parameter int PROX_TICK_DIV = sfq_pkg::SFQ_PROX_TICK_CYCLES
) (
  // Clock and reset.
  input wire logic clock,
  input wire logic rstn,
  // APB slave.
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Acquisition events and data.
  input wire logic sample_valid,
  input wire logic [7:0] sample_data,
  input wire logic auth_done,
  input wire logic ambient_overflow,
  input wire logic led_noncompliant,
  input wire logic temp_ready,
  input wire logic prox_result_valid,
  input wire logic [18:0] prox_result,
  // Acquisition control and interrupt.
  output logic irq,
  output logic proximity_mode,
  output logic slow_tick,
  output logic [7:0] pilot_current,
  output logic [7:0] rate_select
);
  import sfq_pkg::*;

  logic pready_reg, pslverr_reg, irq_reg, tick_reg;
  logic [31:0] prdata_reg;
  logic [7:0] status_reg, status_next, en_main_reg, rate_reg, pilot_reg;
  logic [7:0] prox_thresh_reg, count_reg, count_next, pilot_out_reg;
  logic [7:0] rate_out_reg, rd_mux, target, set_vec, clr_vec;
  logic auth_reg, auth_next, en_auth_reg, statclr_reg, aftype_reg, roll_reg;
  logic [6:0] afull_reg, wr_reg, wr_next, rd_reg, rd_next, lost_reg;
  logic [20:0] div_reg;
  logic [7:0] ram_q;
  sfq_mode_t mode_reg, mode_next;
  logic prox_evt;

  // APB decode; the access phase has one wait state so read data is
  // registered before the master samples it.
  wire [5:0] idx = paddr[7:2];
  wire acc_first = psel & penable & ~pready_reg;
  wire done = psel & penable & pready_reg;
  wire wr_en = done & pwrite;
  wire rd_en = done & ~pwrite;
  wire hit = (idx <= SFQ_IDX_QUEUE_CFG) || (idx == SFQ_IDX_PROX_THRESH) ||
             (idx == SFQ_IDX_PILOT_CUR) || (idx == SFQ_IDX_RATE_SEL);
  wire wr_sel_en_main = wr_en & (idx == SFQ_IDX_IRQ_EN_MAIN);
  wire wr_sel_en_auth = wr_en & (idx == SFQ_IDX_IRQ_EN_AUTH);
  wire wr_sel_rd_idx = wr_en & (idx == SFQ_IDX_READ_INDEX);
  wire wr_sel_thresh = wr_en & (idx == SFQ_IDX_THRESH_CFG);
  wire wr_sel_cfg = wr_en & (idx == SFQ_IDX_QUEUE_CFG);
  wire wr_sel_prox = wr_en & (idx == SFQ_IDX_PROX_THRESH);
  wire wr_sel_pilot = wr_en & (idx == SFQ_IDX_PILOT_CUR);
  wire wr_sel_rate = wr_en & (idx == SFQ_IDX_RATE_SEL);
  wire rd_status = rd_en & (idx == SFQ_IDX_STATUS_MAIN);
  wire rd_auth = rd_en & (idx == SFQ_IDX_AUTH_STATUS);
  wire rd_port = rd_en & (idx == SFQ_IDX_READ_PORT);

  // Flush acts on the write itself; the bit never stores, so reads show 0.
  wire flush = wr_sel_cfg & pwdata[SFQ_BIT_FLUSH];

  // Queue movement. A pop in the same cycle as a full push makes room.
  wire prox_on = en_main_reg[SFQ_BIT_PROX];
  wire in_prox = (mode_reg == SFQ_MODE_PROX);
  wire full = (count_reg == SFQ_DEPTH_COUNT);
  wire pop = rd_port & (count_reg != SFQ_BYTE_RST);
  wire room = ~full | pop;
  wire push_ok = sample_valid &
                 (room | roll_reg | in_prox);
  wire loss = sample_valid & ~room;
  wire rd_bump = push_ok & ~room;
  wire grow = push_ok & room;

  // Read index: flush, then host rewrite, then pop or overwrite.
  assign rd_next = flush ? 7'h00 :
                   wr_sel_rd_idx ? pwdata[6:0] :
                   (pop | rd_bump) ? 7'(rd_reg + 7'h01) : rd_reg;
  assign wr_next = flush ? 7'h00 :
                   push_ok ? 7'(wr_reg + 7'h01) : wr_reg;

  // Occupancy; a host rewrite of the read index recomputes it from the
  // pointer distance, which cannot tell a full queue from an empty one.
  always_comb begin
    count_next = count_reg;
    if (flush) begin
      count_next = SFQ_BYTE_RST;
    end else if (wr_sel_rd_idx) begin
      count_next = {1'b0, 7'(wr_next - pwdata[6:0])};
    end else if (grow & ~pop) begin
      count_next = 8'(count_reg + 8'h01);
    end else if (pop & ~grow) begin
      count_next = 8'(count_reg - 8'h01);
    end
  end

  // Almost-full trigger point and the repeat or once policy.
  assign target = 8'(SFQ_DEPTH_COUNT - {1'b0, afull_reg});
  wire af_before = (count_reg >= target);
  wire af_after = (count_next >= target);
  wire af_evt = push_ok & af_after & (~aftype_reg | ~af_before);

  // Proximity decision against the first slot exposure result.
  wire [18:0] prox_limit = {prox_thresh_reg, SFQ_PROX_SCALE_ZEROS};
  wire below = prox_result < prox_limit;

  always_comb begin
    mode_next = mode_reg;
    prox_evt = 1'b0;
    if (!prox_on) begin
      mode_next = SFQ_MODE_NORMAL;
    end else if (prox_result_valid) begin
      case (mode_reg)
        SFQ_MODE_NORMAL: begin
          if (below) begin
            mode_next = SFQ_MODE_PROX;
            prox_evt = 1'b1;
          end
        end
        SFQ_MODE_PROX: begin
          if (!below) begin
            mode_next = SFQ_MODE_NORMAL;
            prox_evt = 1'b1;
          end
        end
        default: begin
          mode_next = SFQ_MODE_NORMAL;
        end
      endcase
    end
  end

  // Status flags: events set, reads clear, and a set wins over a clear.
  always_comb begin
    set_vec = SFQ_BYTE_RST;
    set_vec[SFQ_BIT_AFULL] = af_evt;
    set_vec[SFQ_BIT_DRDY] = push_ok;
    set_vec[SFQ_BIT_AMB] = ambient_overflow;
    set_vec[SFQ_BIT_PROX] = prox_evt;
    set_vec[SFQ_BIT_LEDC] = led_noncompliant;
    set_vec[SFQ_BIT_TEMP] = temp_ready;
    clr_vec = {8{rd_status}};
    clr_vec[SFQ_BIT_AFULL] = rd_status | (rd_port & statclr_reg);
    clr_vec[SFQ_BIT_DRDY] = rd_status | (rd_port & statclr_reg);
  end
  assign status_next = (status_reg & ~clr_vec | set_vec) & 8'hFC;
  assign auth_next = (auth_reg & ~rd_auth) | auth_done;

  // Read data selection.
  always_comb begin
    rd_mux = SFQ_BYTE_RST;
    case (idx)
      SFQ_IDX_STATUS_MAIN: rd_mux = status_reg;
      SFQ_IDX_AUTH_STATUS: rd_mux = {7'h00, auth_reg};
      SFQ_IDX_IRQ_EN_MAIN: rd_mux = en_main_reg;
      SFQ_IDX_IRQ_EN_AUTH: rd_mux = {7'h00, en_auth_reg};
      SFQ_IDX_WRITE_INDEX: rd_mux = {1'b0, wr_reg};
      SFQ_IDX_READ_INDEX: rd_mux = {1'b0, rd_reg};
      SFQ_IDX_LOST_COUNT: rd_mux = {1'b0, lost_reg};
      SFQ_IDX_OCCUPANCY: rd_mux = count_reg;
      SFQ_IDX_READ_PORT: rd_mux = ram_q;
      SFQ_IDX_THRESH_CFG: rd_mux = {1'b0, afull_reg};
      SFQ_IDX_QUEUE_CFG: rd_mux = {4'h0, statclr_reg, aftype_reg,
                                   roll_reg, 1'b0};
      SFQ_IDX_PROX_THRESH: rd_mux = prox_thresh_reg;
      SFQ_IDX_PILOT_CUR: rd_mux = pilot_reg;
      SFQ_IDX_RATE_SEL: rd_mux = rate_reg;
      default: rd_mux = SFQ_BYTE_RST;
    endcase
  end

  // Sample storage.
  sfq_ram #(
    .WIDTH(8),
    .DEPTH(SFQ_DEPTH),
    .AW(7)
  ) u_ram (
    .clock(clock),
    .wr_en(push_ok),
    .wr_addr(wr_reg),
    .wr_data(sample_data),
    .rd_addr(rd_reg),
    .rd_data(ram_q)
  );

  // Bus answer registers.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      pready_reg <= 1'b0;
      pslverr_reg <= 1'b0;
      prdata_reg <= 32'h0000_0000;
    end else begin
      pready_reg <= acc_first;
      pslverr_reg <= acc_first & ~hit;
      if (acc_first) begin
        prdata_reg <= pwrite ? 32'h0000_0000 : {24'h00_0000, rd_mux};
      end
    end
  end

  // Software-written configuration.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      en_main_reg <= SFQ_BYTE_RST;
      en_auth_reg <= 1'b0;
      afull_reg <= SFQ_AFULL_RST;
      statclr_reg <= 1'b0;
      aftype_reg <= 1'b0;
      roll_reg <= 1'b0;
      prox_thresh_reg <= SFQ_BYTE_RST;
      pilot_reg <= SFQ_BYTE_RST;
      rate_reg <= SFQ_BYTE_RST;
    end else begin
      if (wr_sel_en_main) en_main_reg <= pwdata[7:0] & 8'hFC;
      if (wr_sel_en_auth) en_auth_reg <= pwdata[SFQ_BIT_AUTH];
      if (wr_sel_thresh) afull_reg <= pwdata[6:0];
      if (wr_sel_cfg) begin
        statclr_reg <= pwdata[SFQ_BIT_STATCLR];
        aftype_reg <= pwdata[SFQ_BIT_AFTYPE];
        roll_reg <= pwdata[SFQ_BIT_ROLL];
      end
      if (wr_sel_prox) prox_thresh_reg <= pwdata[7:0];
      if (wr_sel_pilot) pilot_reg <= pwdata[7:0];
      if (wr_sel_rate) rate_reg <= pwdata[7:0];
    end
  end

  // Queue state, flags and mode.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      wr_reg <= 7'h00;
      rd_reg <= 7'h00;
      count_reg <= SFQ_BYTE_RST;
      lost_reg <= 7'h00;
      status_reg <= SFQ_BYTE_RST;
      auth_reg <= 1'b0;
      mode_reg <= SFQ_MODE_NORMAL;
    end else begin
      wr_reg <= wr_next;
      rd_reg <= rd_next;
      count_reg <= count_next;
      if (loss && lost_reg != SFQ_LOST_MAX) begin
        lost_reg <= 7'(lost_reg + 7'h01);
      end
      status_reg <= status_next;
      auth_reg <= auth_next;
      mode_reg <= mode_next;
    end
  end

  // Proximity pacing divider; it only runs in proximity mode so a normal
  // acquisition sees no stray ticks.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      div_reg <= 21'h00_0000;
      tick_reg <= 1'b0;
    end else if (!in_prox) begin
      div_reg <= 21'h00_0000;
      tick_reg <= 1'b0;
    end else begin
      tick_reg <= (div_reg == 21'(PROX_TICK_DIV - 1));
      div_reg <= (div_reg == 21'(PROX_TICK_DIV - 1)) ? 21'h00_0000 :
                 21'(div_reg + 21'h00_0001);
    end
  end

  // Interrupt and acquisition outputs. In proximity mode the sequencer gets
  // the pilot current, and zero otherwise; the configured rate goes out in both modes.
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      irq_reg <= 1'b0;
      pilot_out_reg <= SFQ_BYTE_RST;
      rate_out_reg <= SFQ_BYTE_RST;
    end else begin
      irq_reg <= (|(status_reg & en_main_reg)) |
                 (auth_reg & en_auth_reg);
      pilot_out_reg <= in_prox ? pilot_reg : SFQ_BYTE_RST;
      rate_out_reg <= rate_reg;
    end
  end

  assign prdata = prdata_reg;
  assign pready = pready_reg;
  assign pslverr = pslverr_reg;
  assign irq = irq_reg;
  assign proximity_mode = (mode_reg == SFQ_MODE_PROX);
  assign slow_tick = tick_reg;
  assign pilot_current = pilot_out_reg;
  assign rate_select = rate_out_reg;

  // Checks.
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);

  chk_auth_set: assert property (auth_done |=> auth_reg)
    else $error("auth flag not set after finish");
  chk_auth_clear: assert property (rd_auth && !auth_done
    |=> !auth_reg)
    else $error("auth flag not cleared by read");
  chk_irq_masked: assert property ((en_main_reg == 8'h00)
    && !en_auth_reg |=> !irq_reg)
    else $error("irq raised while all sources disabled");
  chk_prox_off: assert property (!prox_on |=> !proximity_mode)
    else $error("proximity mode while disabled");
  chk_prox_enter: assert property (prox_on && prox_result_valid &&
    below && !in_prox && !rd_status
    |=> proximity_mode && status_reg[SFQ_BIT_PROX])
    else $error("entry into proximity not flagged");
  chk_wr_advance: assert property (push_ok && !flush
    |=> wr_reg == 7'($past(wr_reg) + 7'h01))
    else $error("write index did not advance");
  chk_lost_sat: assert property (loss && lost_reg == SFQ_LOST_MAX
    |=> lost_reg == SFQ_LOST_MAX)
    else $error("lost counter wrapped");
  chk_drop_hold: assert property (sample_valid && full &&
    !roll_reg && !in_prox && !pop && !flush |=> $stable(wr_reg))
    else $error("write index moved on dropped sample");
  chk_flush_empty: assert property (flush
    |=> count_reg == 8'h00 && wr_reg == 7'h00 && rd_reg == 7'h00)
    else $error("flush did not empty queue");
  chk_port_clear: assert property (rd_port && statclr_reg
    && !push_ok |=> !status_reg[SFQ_BIT_DRDY] && !status_reg[SFQ_BIT_AFULL])
    else $error("data read did not clear flags");
  chk_answer_len: assert property (psel && penable && !pready_reg
    |=> pready_reg)
    else $error("bus answer late");

  cov_rollover: cover property (sample_valid && full && roll_reg);
  cov_prox_exit: cover property (in_prox ##1 !in_prox);
  cov_afull: cover property (af_evt);
  cov_flush: cover property (flush && count_reg != 8'h00);

endmodule // sfq_top
